// *** pkg/adcs_pkg.sv ***
// package: register map, field layout, counts and states of the converter sequencer
package adcs_pkg;
	// register byte offsets
	localparam logic [7:0] ADCS_OFF_CTRL = 8'h00;
	localparam logic [7:0] ADCS_OFF_TIMING = 8'h04;
	localparam logic [7:0] ADCS_OFF_PINCFG = 8'h08;
	localparam logic [7:0] ADCS_OFF_RESH = 8'h0c;
	localparam logic [7:0] ADCS_OFF_RESL = 8'h10;
	localparam logic [7:0] ADCS_OFF_STAT = 8'h14;
	localparam logic [7:0] ADCS_OFF_PORT = 8'h18;
	// control register fields
	localparam int ADCS_CTRL_ON = 0;
	localparam int ADCS_CTRL_GO = 1;
	localparam int ADCS_CTRL_CHS = 2;
	// converter_timing_control fields
	localparam int ADCS_TIM_CLKS = 0;
	localparam int ADCS_TIM_ACQ = 3;
	// status register fields
	localparam int ADCS_STAT_FLAG = 0;
	// result width and split
	localparam int ADCS_RES_W = 10;
	localparam int ADCS_RESH_W = 2;
	// values after reset
	localparam logic [2:0] ADCS_RST_CHS = 3'h0;
	localparam logic [2:0] ADCS_RST_ACQ = 3'h0;
	localparam logic [2:0] ADCS_RST_CLKS = 3'h0;
	localparam logic [7:0] ADCS_RST_APC = 8'h00;
	localparam logic [9:0] ADCS_RST_RES = 10'h000;
	// periods per conversion, recovery, start delay in clocks
	localparam logic [4:0] ADCS_CONV_TADS = 5'h0b;
	localparam logic [4:0] ADCS_RECOV_TADS = 5'h02;
	localparam logic [4:0] ADCS_INSTR_CYC = 5'h04;
	// acquisition length per code, in bit periods
	localparam logic [4:0] ADCS_ACQ_T1 = 5'h02;
	localparam logic [4:0] ADCS_ACQ_T2 = 5'h04;
	localparam logic [4:0] ADCS_ACQ_T3 = 5'h06;
	localparam logic [4:0] ADCS_ACQ_T4 = 5'h08;
	localparam logic [4:0] ADCS_ACQ_T5 = 5'h0c;
	localparam logic [4:0] ADCS_ACQ_T6 = 5'h10;
	localparam logic [4:0] ADCS_ACQ_T7 = 5'h14;
	// conversion_clock_select codes and their divisors
	localparam logic [2:0] ADCS_CLKS_D2 = 3'h0;
	localparam logic [2:0] ADCS_CLKS_D4 = 3'h4;
	localparam logic [2:0] ADCS_CLKS_D8 = 3'h1;
	localparam logic [2:0] ADCS_CLKS_D16 = 3'h5;
	localparam logic [2:0] ADCS_CLKS_D32 = 3'h2;
	localparam logic [2:0] ADCS_CLKS_D64 = 3'h6;
	localparam logic [1:0] ADCS_CLKS_RC = 2'h3;
	localparam logic [6:0] ADCS_DIV2 = 7'h02;
	localparam logic [6:0] ADCS_DIV4 = 7'h04;
	localparam logic [6:0] ADCS_DIV8 = 7'h08;
	localparam logic [6:0] ADCS_DIV16 = 7'h10;
	localparam logic [6:0] ADCS_DIV32 = 7'h20;
	localparam logic [6:0] ADCS_DIV64 = 7'h40;
	// sequencer states
	typedef enum logic [4:0] {
		ADCS_SAMPLE = 5'b00001,
		ADCS_DELAY = 5'b00010,
		ADCS_ACQ = 5'b00100,
		ADCS_CONV = 5'b01000,
		ADCS_RECOV = 5'b10000
	} adcs_state_t;
endpackage : adcs_pkg

// *** hw/adcs_seq.sv ***
// converter acquisition and conversion sequencer with an ahb-lite register slave
// What this block does
// - code 000: start converts with no acquisition
// - nonzero code: keep sampling, then convert
// - code 010 gives four-period acquisition
// - done: clear start, set flag, resample
// - start flag covers acquisition and conversion
// - conversion takes eleven bit periods
// - clock select picks divisor or rc
// - keep converting in low-power idle
// - code 000: start waits one instruction
// - analog pins read zero on port
// - sequence ignores channel and direction
// - clearing start aborts; result kept
// - two-period wait after done or abort
// - completion loads result high and low
// - reset powers off and aborts
// - trigger sets start when powered
`timescale 1ns/1ps
module adcs_seq (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// compare unit special event
	input wire logic trig_in,
	// analog core
	input wire logic cmp_in,
	input wire logic rc_clk_in,
	output logic sample_out,
	output logic [9:0] dac_out,
	output logic [2:0] chan_out,
	// port pins, read back through the port register
	input wire logic [7:0] port_pins_in
);
	// whole state of the block
	typedef struct packed {
		logic on;
		logic go;
		logic [2:0] chs;
		logic [2:0] acq;
		logic [2:0] clks;
		logic [7:0] apc;
		logic [9:0] res;
		logic flag;
		adcs_pkg::adcs_state_t st;
		logic [6:0] pre;
		logic [4:0] tcnt;
		logic [9:0] sar;
		logic [9:0] trial;
		logic wpend;
		logic [7:0] waddr;
		logic [31:0] rdata;
		logic hready;
		logic [7:0] pin1;
		logic [7:0] pin2;
		logic rc1;
		logic rc2;
		logic rc3;
		logic smp; // sampling switch, registered for the output
	} adcs_regs_t;
	adcs_regs_t s_reg;
	adcs_regs_t s_next;
	// bit period divisor for an oscillator code
	function automatic logic [6:0] adcs_div(input logic [2:0] code);
		case (code)
			adcs_pkg::ADCS_CLKS_D2: adcs_div = adcs_pkg::ADCS_DIV2;
			adcs_pkg::ADCS_CLKS_D4: adcs_div = adcs_pkg::ADCS_DIV4;
			adcs_pkg::ADCS_CLKS_D8: adcs_div = adcs_pkg::ADCS_DIV8;
			adcs_pkg::ADCS_CLKS_D16: adcs_div = adcs_pkg::ADCS_DIV16;
			adcs_pkg::ADCS_CLKS_D32: adcs_div = adcs_pkg::ADCS_DIV32;
			adcs_pkg::ADCS_CLKS_D64: adcs_div = adcs_pkg::ADCS_DIV64;
			default: adcs_div = adcs_pkg::ADCS_DIV2;
		endcase
	endfunction : adcs_div
	// acquisition length in bit periods; zero means none
	function automatic logic [4:0] adcs_acq_len(input logic [2:0] code);
		case (code)
			3'h1: adcs_acq_len = adcs_pkg::ADCS_ACQ_T1;
			3'h2: adcs_acq_len = adcs_pkg::ADCS_ACQ_T2;
			3'h3: adcs_acq_len = adcs_pkg::ADCS_ACQ_T3;
			3'h4: adcs_acq_len = adcs_pkg::ADCS_ACQ_T4;
			3'h5: adcs_acq_len = adcs_pkg::ADCS_ACQ_T5;
			3'h6: adcs_acq_len = adcs_pkg::ADCS_ACQ_T6;
			3'h7: adcs_acq_len = adcs_pkg::ADCS_ACQ_T7;
			default: adcs_acq_len = 5'h00;
		endcase
	endfunction : adcs_acq_len
	// next-state logic: bus writes first, then trigger, then sequencer
	always_comb
	begin
		logic rc_mode;
		logic tick;
		logic addr_ok;
		logic [6:0] div;
		rc_mode = 1'b0;
		tick = 1'b0;
		addr_ok = 1'b0;
		div = 7'h00;
		s_next = s_reg;
		// synchronisers: first stage feeds only the second
		s_next.pin1 = port_pins_in;
		s_next.pin2 = s_reg.pin1;
		s_next.rc1 = rc_clk_in;
		s_next.rc2 = s_reg.rc1;
		s_next.rc3 = s_reg.rc2;
		// zero wait states, always okay
		s_next.hready = 1'b1;
		// data phase of a write
		if (s_reg.wpend)
		begin
			case (s_reg.waddr)
				adcs_pkg::ADCS_OFF_CTRL:
				begin
					s_next.on = hwdata_in[adcs_pkg::ADCS_CTRL_ON];
					s_next.go = hwdata_in[adcs_pkg::ADCS_CTRL_GO];
					s_next.chs = hwdata_in[adcs_pkg::ADCS_CTRL_CHS +: 3];
				end
				adcs_pkg::ADCS_OFF_TIMING:
				begin
					s_next.clks = hwdata_in[adcs_pkg::ADCS_TIM_CLKS +: 3];
					s_next.acq = hwdata_in[adcs_pkg::ADCS_TIM_ACQ +: 3];
				end
				adcs_pkg::ADCS_OFF_PINCFG: s_next.apc = hwdata_in[7:0];
				adcs_pkg::ADCS_OFF_RESH:
					s_next.res[9:8] = hwdata_in[adcs_pkg::ADCS_RESH_W-1:0];
				adcs_pkg::ADCS_OFF_RESL: s_next.res[7:0] = hwdata_in[7:0];
				// write one to clear the flag
				adcs_pkg::ADCS_OFF_STAT:
					if (hwdata_in[adcs_pkg::ADCS_STAT_FLAG])
						s_next.flag = 1'b0;
				// unmapped or read-only: ignored
				default: ;
			endcase
		end
		// special event sets start only when powered
		if (trig_in && s_next.on)
			s_next.go = 1'b1;
		// start cannot stand while the converter is off
		if (!s_next.on)
			s_next.go = 1'b0;
		// bit period tick: divided oscillator or synced rc edge
		// select divisor or rc
		rc_mode = (s_reg.clks[1:0] == adcs_pkg::ADCS_CLKS_RC);
		div = adcs_div(s_reg.clks);
		// no idle gating here: ticks keep running in idle
		tick = rc_mode ? (s_reg.rc2 && !s_reg.rc3) : (s_reg.pre == div - 7'h01);
		s_next.pre = (tick || rc_mode) ? 7'h00 : s_reg.pre + 7'h01;
		// sequencer
		// channel and pin direction never gate the sequence
		case (s_reg.st)
			adcs_pkg::ADCS_SAMPLE:
			begin
				s_next.pre = 7'h00;
				s_next.tcnt = 5'h00;
				if (s_next.go)
				begin
					if (s_reg.acq == 3'h0)
						s_next.st = adcs_pkg::ADCS_DELAY;
					else
						s_next.st = adcs_pkg::ADCS_ACQ;
				end
			end
			adcs_pkg::ADCS_DELAY:
			begin
				s_next.pre = 7'h00;
				s_next.tcnt = s_reg.tcnt + 5'h01;
				if (!s_next.go)
				begin
					s_next.st = adcs_pkg::ADCS_RECOV;
					s_next.tcnt = 5'h00;
				end
				else if (s_reg.tcnt == adcs_pkg::ADCS_INSTR_CYC - 5'h01)
				begin
					s_next.st = adcs_pkg::ADCS_CONV;
					s_next.tcnt = 5'h00;
					s_next.sar = 10'h200;
					s_next.trial = 10'h200;
				end
			end
			adcs_pkg::ADCS_ACQ:
			begin
				// start flag stays set; phase not visible
				if (tick)
					s_next.tcnt = s_reg.tcnt + 5'h01;
				if (!s_next.go)
				begin
					s_next.st = adcs_pkg::ADCS_RECOV;
					s_next.tcnt = 5'h00;
					s_next.pre = 7'h00;
				end
				else if (tick && s_reg.tcnt == adcs_acq_len(s_reg.acq) - 5'h01)
				begin
					s_next.st = adcs_pkg::ADCS_CONV;
					s_next.tcnt = 5'h00;
					s_next.sar = 10'h200;
					s_next.trial = 10'h200;
				end
			end
			adcs_pkg::ADCS_CONV:
			begin
				if (!s_next.go)
				begin
					s_next.st = adcs_pkg::ADCS_RECOV;
					s_next.tcnt = 5'h00;
					s_next.pre = 7'h00;
				end
				else if (tick)
				begin
					s_next.tcnt = s_reg.tcnt + 5'h01;
					if (s_reg.trial != 10'h000)
					begin
						s_next.sar = (cmp_in ? s_reg.sar : (s_reg.sar & ~s_reg.trial)) | (s_reg.trial >> 1);
						s_next.trial = s_reg.trial >> 1;
					end
					if (s_reg.tcnt == adcs_pkg::ADCS_CONV_TADS - 5'h01)
					begin
						s_next.res = s_reg.sar;
						s_next.go = 1'b0;
						s_next.flag = 1'b1;
						s_next.st = adcs_pkg::ADCS_RECOV;
						s_next.tcnt = 5'h00;
					end
				end
			end
			adcs_pkg::ADCS_RECOV:
			begin
				if (tick)
					s_next.tcnt = s_reg.tcnt + 5'h01;
				if (tick && s_reg.tcnt == adcs_pkg::ADCS_RECOV_TADS - 5'h01)
				begin
					s_next.st = adcs_pkg::ADCS_SAMPLE;
					s_next.tcnt = 5'h00;
				end
			end
			default:
			begin
				s_next.st = adcs_pkg::ADCS_SAMPLE;
				s_next.tcnt = 5'h00;
			end
		endcase
		// powered off: sequencer parks in sampling, idle
		if (!s_next.on)
		begin
			s_next.st = adcs_pkg::ADCS_SAMPLE;
			s_next.tcnt = 5'h00;
		end
		// sampling switch closed when powered and not converting or recovering
		s_next.smp = s_next.on && !(s_next.st == adcs_pkg::ADCS_CONV || s_next.st == adcs_pkg::ADCS_RECOV);
		// address phase: note writes, prepare read data from the updated
		// state, so a write just before a read of the same register is seen
		addr_ok = hsel_in && htrans_in[1] && hready_in;
		s_next.wpend = addr_ok && hwrite_in && haddr_in[31:8] == 24'h00_0000; // out-of-map writes dropped
		s_next.waddr = haddr_in[7:0];
		s_next.rdata = 32'h0000_0000;
		if (addr_ok && !hwrite_in && haddr_in[31:8] == 24'h00_0000)
		begin
			case (haddr_in[7:0])
				adcs_pkg::ADCS_OFF_CTRL:
				begin
					s_next.rdata[adcs_pkg::ADCS_CTRL_ON] = s_next.on;
					s_next.rdata[adcs_pkg::ADCS_CTRL_GO] = s_next.go;
					s_next.rdata[adcs_pkg::ADCS_CTRL_CHS +: 3] = s_next.chs;
				end
				adcs_pkg::ADCS_OFF_TIMING:
				begin
					s_next.rdata[adcs_pkg::ADCS_TIM_CLKS +: 3] = s_next.clks;
					s_next.rdata[adcs_pkg::ADCS_TIM_ACQ +: 3] = s_next.acq;
				end
				adcs_pkg::ADCS_OFF_PINCFG: s_next.rdata[7:0] = s_next.apc;
				adcs_pkg::ADCS_OFF_RESH:
					s_next.rdata[adcs_pkg::ADCS_RESH_W-1:0] = s_next.res[9:8];
				adcs_pkg::ADCS_OFF_RESL: s_next.rdata[7:0] = s_next.res[7:0];
				adcs_pkg::ADCS_OFF_STAT: s_next.rdata[adcs_pkg::ADCS_STAT_FLAG] = s_next.flag;
				adcs_pkg::ADCS_OFF_PORT: s_next.rdata[7:0] = s_next.pin2 & ~s_next.apc;
				default: ;
			endcase
		end
	end
	// state register
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			s_reg <= '0;
			s_reg.chs <= adcs_pkg::ADCS_RST_CHS;
			s_reg.acq <= adcs_pkg::ADCS_RST_ACQ;
			s_reg.clks <= adcs_pkg::ADCS_RST_CLKS;
			s_reg.apc <= adcs_pkg::ADCS_RST_APC;
			s_reg.res <= adcs_pkg::ADCS_RST_RES;
			s_reg.st <= adcs_pkg::ADCS_SAMPLE;
			s_reg.hready <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
	// outputs straight from the state flops; error response tied low
	assign hrdata_out = s_reg.rdata;
	assign hreadyout_out = s_reg.hready;
	assign hresp_out = 1'b0;
	assign dac_out = s_reg.sar;
	assign chan_out = s_reg.chs;
	assign sample_out = s_reg.smp;
endmodule : adcs_seq

// *** bench/adcs_seq_assertions.sv ***
// checker: bus and sequencer timing relations seen at the ports
`timescale 1ns/1ps
module adcs_chk (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// bus side
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	// sequencer side
	input wire logic trig_in,
	input wire logic sample_out,
	input wire logic [2:0] chan_out
);
	logic req; // transfer taken at this edge
	logic wc_q; // control write in data phase
	logic wt_q; // timing write in data phase
	logic on_q; // shadow of power-on bit
	logic ab_q; // control touched while not sampling
	logic [5:0] tim_q; // shadow of timing fields
	logic [11:0] lo_q; // cycles spent not sampling
	logic [11:0] dv; // clocks per bit period
	assign req = hsel_in & htrans_in[1];
	// zero for the rc source, whose ticks we cannot count
	assign dv = (tim_q[1:0] == 2'h3) ? 12'h000 : 12'h002 << {tim_q[1:0], tim_q[2]};
	// shadow registers rebuilt from bus traffic, plus counters fed by sample_out
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			wc_q <= 1'b0;
			wt_q <= 1'b0;
			on_q <= 1'b0;
			ab_q <= 1'b1;
			tim_q <= 6'h00;
			lo_q <= 12'h000;
		end
		else
		begin
			wc_q <= req & hwrite_in & (haddr_in == 32'h0);
			wt_q <= req & hwrite_in & (haddr_in == 32'h4);
			on_q <= wc_q ? hwdata_in[0] : on_q;
			tim_q <= wt_q ? hwdata_in[5:0] : tim_q;
			lo_q <= sample_out ? 12'h000 : lo_q + 12'h001;
			ab_q <= sample_out ? 1'b0 : (ab_q | wc_q);
		end
	end
	okay_resp_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) hresp_out == 1'b0)
	else $error("error response seen");
	zero_wait_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) hreadyout_out == 1'b1)
	else $error("wait state inserted");
	idle_rdata_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) !(req && !hwrite_in) |=> hrdata_out == 32'h0)
	else $error("read data without a read");
	chan_follow_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) wc_q |=> chan_out == $past(hwdata_in[4:2]))
	else $error("channel not taken from control write");
	read_chan_a:
	assert property (@(posedge mclk_in) disable iff (rst_in)
		req && !hwrite_in && haddr_in == 32'h0 |=> hrdata_out[4:2] == chan_out)
	else $error("control readback differs from channel");
	reset_off_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) $fell(rst_in) |-> !sample_out)
	else $error("sampling right after reset");
	off_stop_a:
	assert property (@(posedge mclk_in) disable iff (rst_in) wc_q && !hwdata_in[0] |=> !sample_out)
	else $error("sampling while powered off");
	start_delay_a:
	assert property (@(posedge mclk_in) disable iff (rst_in)
		(trig_in || (wc_q && hwdata_in[1:0] == 2'h3)) && on_q && sample_out && tim_q[5:3] == 3'h0
		|-> sample_out[*5] ##1 !sample_out)
	else $error("start delay wrong");
	full_conv_a:
	assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(sample_out) && !ab_q && dv != 12'h000 |-> lo_q == 12'd13 * dv)
	else $error("conversion plus recovery length wrong");
endmodule : adcs_chk
bind adcs_seq adcs_chk chk (.mclk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in,
	.hrdata_out, .hreadyout_out, .hresp_out, .trig_in, .sample_out, .chan_out);

// *** bench/adcs_analog_model.sv ***
// model: sample-hold, comparator and private rc oscillator
`timescale 1ns/1ps
module adcs_analog_model #(
	parameter time RC_HALF = 310ns
) (
	// level at the pin, trial word, sampling switch
	input wire logic [9:0] level_in,
	input wire logic [9:0] dac_in,
	input wire logic sample_in,
	// comparator result and rc clock
	output logic cmp_out,
	output logic rc_clk_out
);
	logic [9:0] held = 10'h000; // hold capacitor
	always @(sample_in or level_in)
		if (sample_in)
			held = level_in;
	// combinational comparator, no settling modelled
	assign cmp_out = (held >= dac_in);
	// oscillator free-runs like the real one
	initial rc_clk_out = 1'b0;
	always #(RC_HALF) rc_clk_out = ~rc_clk_out;
endmodule : adcs_analog_model

// *** bench/adcs_seq_tb_top.sv ***
// testbench: registers, conversion timing, abort and trigger
`timescale 1ns/1ps
module adcs_seq_tb_top;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic trig = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hrdy, smp, cmp, rc;
	logic [9:0] dac;
	logic [9:0] lvl = 10'h000;
	logic [7:0] pins = 8'h00;
	logic [7:0] cfg;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int seed = 67462;
	int n;
	int acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // bit periods per code
	always #25 mclk_in = ~mclk_in;
	adcs_seq dut (.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(), .trig_in(trig), .cmp_in(cmp), .rc_clk_in(rc),
		.sample_out(smp), .dac_out(dac), .chan_out(), .port_pins_in(pins));
	adcs_analog_model ana (.level_in(lvl), .dac_in(dac), .sample_in(smp), .cmp_out(cmp), .rc_clk_out(rc));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// single word transfer; read data taken at the data edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : xfer
	// count edges until sampling shows v
	task automatic wait_smp(input logic v);
		n = 0;
		while (smp !== v && n < 4000)
		begin
			@(posedge mclk_in);
			n++;
		end
	endtask : wait_smp
	// edges from the start write's data edge until sampling is seen low:
	// one instruction of four clocks, or the acquisition periods, plus one
	// edge because the bench reads each flop an edge after it loads
	function automatic int lead(input logic [2:0] c);
		int dv;
		dv = 2 << {c[1:0], c[2]};
		return (c == 3'h0) ? 5 : acq_tab[c] * dv + 1;
	endfunction : lead
	// poll for done, check result and flag, then clear it
	task automatic done_chk(input logic [9:0] exp);
		do xfer(1'b0, 8'h00, 32'h0); while (rd[1] === 1'b1);
		xfer(1'b0, 8'h0c, 32'h0);
		chk(rd, {30'h0, exp[9:8]});
		xfer(1'b0, 8'h10, 32'h0);
		chk(rd, {24'h0, exp[7:0]});
		xfer(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h1);
		xfer(1'b1, 8'h14, 32'h1);
		wait_smp(1'b1);
	endtask : done_chk
	// watchdog
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		// every place reads zero after reset, unmapped one too
		for (int a = 0; a < 32; a += 4)
		begin
			xfer(1'b0, 8'(a), 32'h0);
			chk(rd, 32'h0);
		end
		pins <= 8'($random(seed));
		cfg = 8'($random(seed));
		xfer(1'b1, 8'h08, {24'h0, cfg});
		xfer(1'b0, 8'h18, 32'h0);
		chk(rd, {24'h0, pins & ~cfg});
		xfer(1'b1, 8'h00, 32'h1);
		// every clock and acquisition code, extremes first
		for (int i = 0; i < 8; i++)
		begin
			lvl = (i < 2) ? {10{i[0]}} : 10'($random(seed));
			// timing rewritten only while sampling; codes x11 use the rc clock
			xfer(1'b1, 8'h04, {26'h0, 3'(i), 3'(i)});
			xfer(1'b1, 8'h00, {27'h0, 3'(i), 2'h3});
			wait_smp(1'b0);
			if (i[1:0] != 2'h3)
				chk(n, lead(3'(i)));
			xfer(1'b0, 8'h00, 32'h0);
			chk({31'h0, rd[1]}, 32'h1);
			done_chk(lvl);
		end
		// abort keeps the last written result
		xfer(1'b1, 8'h10, 32'ha5);
		xfer(1'b1, 8'h0c, 32'h2);
		xfer(1'b1, 8'h04, 32'h6);
		xfer(1'b1, 8'h00, 32'h3);
		wait_smp(1'b0);
		repeat (100) @(posedge mclk_in);
		xfer(1'b1, 8'h00, 32'h1);
		wait_smp(1'b1);
		// two recovery periods at divisor 64, plus the edge of read lag
		chk(n, 2 * 64 + 1);
		xfer(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h2);
		xfer(1'b0, 8'h10, 32'h0);
		chk(rd, 32'ha5);
		xfer(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		// trigger ignored when off, starts when on
		xfer(1'b1, 8'h04, 32'h0);
		lvl = 10'($random(seed));
		for (int p = 0; p < 2; p++)
		begin
			xfer(1'b1, 8'h00, 32'(p));
			@(posedge mclk_in);
			trig <= 1'b1;
			@(posedge mclk_in);
			trig <= 1'b0;
			xfer(1'b0, 8'h00, 32'h0);
			chk({31'h0, rd[1]}, 32'(p));
		end
		done_chk(lvl);
		report_and_stop();
	end
endmodule : adcs_seq_tb_top
